// >>> common/jls_cfg.svh
`ifndef JLS_CFG_SVH
`define JLS_CFG_SVH
`define JLS_CLK_HZ 100000000
`define JLS_HB_HALF_MS 1000
`define JLS_JOB_W 9
`define JLS_JOB_MIN 9'h001
`define JLS_JOB_MAX 9'h199
`define JLS_BCD_DIGIT_MAX 4'h9
`define JLS_REG_SYS_CFG 8'h00
`define JLS_REG_HORN_EN 8'h04
`define JLS_REG_STATUS 8'h08
`define JLS_REG_IRQ_STAT 8'h0C
`define JLS_REG_IRQ_MASK 8'h10
`define JLS_REG_JOB_BASE 8'h14
`define JLS_SYS_CFG_ALARM_EN 0
`define JLS_STATUS_ALARM 0
`define JLS_STATUS_HB 1
`define JLS_STATUS_LINK 2
`define JLS_STATUS_FW_ERR 3
`define JLS_STATUS_PEND_LSB 8
`define JLS_JOB_ACTIVE_LSB 0
`define JLS_JOB_PEND_LSB 16
`define JLS_JOB_PEND_V 31
`define JLS_IRQ_REJECT 0
`define JLS_IRQ_ACTIVATE 1
`define JLS_IRQ_LINK_LOST 2
`define JLS_IRQ_ALARM 3
`define JLS_IRQ_W 4
`define JLS_ALARM_EN_RST 1'b0
`define JLS_IRQ_MASK_RST 4'h0
`endif

// >>> common/jls_pkg.sv
package jls_pkg;
	typedef logic [8:0] jls_job_t;
	typedef enum logic [0:0] {
		JLS_BUS_IDLE = 1'b0,
		JLS_BUS_ANS = 1'b1
	} jls_bus_e;
endpackage

// >>> common/jls_job_if.sv
`timescale 1ns/1ns
interface jls_job_if;
	import jls_pkg::*;
	logic cap;
	jls_job_t job;
	logic job_ok;
	logic running;
	jls_job_t active;
	jls_job_t pend;
	logic pend_v;
	logic act_evt;
	logic rej_evt;
	modport top (output cap, job, job_ok, running,
		input active, pend, pend_v, act_evt, rej_evt);
	modport slot (input cap, job, job_ok, running,
		output active, pend, pend_v, act_evt, rej_evt);
endinterface

// >>> logic/jls_sync.sv
`timescale 1ns/1ns
module jls_sync #(
	parameter int W = 1
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst_n,
	// Data.
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule // jls_sync

// >>> logic/jls_job_slot.sv
`timescale 1ns/1ns
`include "jls_cfg.svh"
module jls_job_slot
	import jls_pkg::*;
(
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst_n,
	// Link to the top.
	jls_job_if.slot jif
);
	logic run_q;
	jls_job_t active_q;
	jls_job_t pend_q;
	logic pend_v_q;
	logic act_evt_q;
	logic rej_evt_q;
	wire halt_evt = run_q & ~jif.running;
	wire take = jif.cap & jif.job_ok;
	wire take_now = take & ~jif.running;
	wire take_later = take & jif.running;
	wire release_pend = ~take & halt_evt & pend_v_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_q <= 1'b0;
			active_q <= '0;
			pend_q <= '0;
			pend_v_q <= 1'b0;
			act_evt_q <= 1'b0;
			rej_evt_q <= 1'b0;
		end else begin
			run_q <= jif.running;
			act_evt_q <= take_now | release_pend;
			rej_evt_q <= jif.cap & ~jif.job_ok;
			if (take_now) begin
				active_q <= jif.job;
				pend_v_q <= 1'b0;
			end else if (take_later) begin
				pend_q <= jif.job;
				pend_v_q <= 1'b1;
			end else if (release_pend) begin
				active_q <= pend_q;
				pend_v_q <= 1'b0;
			end
		end
	end

	assign jif.active = active_q;
	assign jif.pend = pend_q;
	assign jif.pend_v = pend_v_q;
	assign jif.act_evt = act_evt_q;
	assign jif.rej_evt = rej_evt_q;

	cap_now_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		take_now |=> active_q == $past(jif.job) && !pend_v_q)
		else $error("Idle capture did not become active.");
	cap_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		take_later |=> $stable(active_q) && pend_v_q && pend_q == $past(jif.job))
		else $error("Running capture was not held pending.");
	pend_go_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		release_pend |=> active_q == $past(pend_q) && !pend_v_q)
		else $error("Pending job not activated on halt.");
	pend_over_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		take_later && pend_v_q |=> pend_v_q && pend_q == $past(jif.job))
		else $error("Newer pending job did not replace older.");
	bad_job_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		jif.cap && !jif.job_ok |=> $stable(active_q) && $stable(pend_q)
			&& $stable(pend_v_q) && rej_evt_q)
		else $error("Invalid job changed the queue.");
	no_cap_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!jif.cap && !halt_evt |=> $stable(active_q) && $stable(pend_q))
		else $error("Job changed without a load strobe.");
endmodule // jls_job_slot

// >>> logic/jls_top.sv
// What this block does
// - Strobe rising edge captures the shared job.
// - Halted, ready or faulted: activate job immediately.
// - Running: hold job until halt or fault.
// - Pending storage holds exactly one job.
// - Newer captured job overwrites the pending one.
// - Job lines read only on strobe edge.
// - Job numbers range from 1 to 199.
// - Alarm follows system fault when enabled.
// - Per-applicator switch routes its fault to alarm.
// - Alarm disable blocks applicator faults too.
// - Heartbeat toggles near 0.5 Hz unless firmware fails.
// - Host-link output follows the Ethernet link.
//
// Our own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "jls_cfg.svh"
module jls_top
	import jls_pkg::*;
#(
	parameter int N_APP = 4,
	parameter int unsigned HB_HALF_CYC = `JLS_HB_HALF_MS * (`JLS_CLK_HZ / 1000)
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic nrst,
	// Avalon-MM slave.
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq,
	// Job load and link pins.
	input wire logic [8:0] job_bcd_pin,
	input wire logic [N_APP-1:0] load_strobe_pin,
	input wire logic link_up_pin,
	// Applicator and system state.
	input wire logic [N_APP-1:0] app_run,
	input wire logic [N_APP-1:0] app_fault,
	input wire logic sys_fault,
	input wire logic fw_err,
	// System outputs.
	output logic alarm_out,
	output logic heartbeat_out,
	output logic host_link_out,
	output logic [N_APP*9-1:0] active_job
);
	localparam int HBW = $clog2(HB_HALF_CYC + 1);

	// ************************************************************
	// Reset release and pin synchronisers.
	// ************************************************************
	logic rst_meta_q;
	logic rst_n;
	logic [8:0] job_s;
	logic [N_APP-1:0] strobe_s;
	logic link_s;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	jls_sync #(.W(9 + N_APP + 1)) u_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.d({job_bcd_pin, load_strobe_pin, link_up_pin}),
		.q({job_s, strobe_s, link_s})
	);

	// ************************************************************
	// Job capture and applicator slots.
	// ************************************************************
	logic [N_APP-1:0] strobe_q;
	logic [N_APP-1:0] cap;
	logic [N_APP-1:0] act_evt;
	logic [N_APP-1:0] rej_evt;
	logic [N_APP-1:0] pend_v;
	jls_job_t act_arr [N_APP];
	jls_job_t pend_arr [N_APP];
	wire digits_ok = job_s[3:0] <= `JLS_BCD_DIGIT_MAX && job_s[7:4] <= `JLS_BCD_DIGIT_MAX;
	wire range_ok = job_s >= `JLS_JOB_MIN && job_s <= `JLS_JOB_MAX;
	wire job_ok = digits_ok & range_ok;
	wire [N_APP-1:0] running = app_run & ~app_fault;

	assign cap = strobe_s & ~strobe_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			strobe_q <= '0;
		end else begin
			strobe_q <= strobe_s;
		end
	end

	for (genvar i = 0; i < N_APP; i++) begin : g_slot
		jls_job_if jif ();
		assign jif.cap = cap[i];
		assign jif.job = job_s;
		assign jif.job_ok = job_ok;
		assign jif.running = running[i];
		assign act_arr[i] = jif.active;
		assign pend_arr[i] = jif.pend;
		assign pend_v[i] = jif.pend_v;
		assign act_evt[i] = jif.act_evt;
		assign rej_evt[i] = jif.rej_evt;
		assign active_job[i*9 +: 9] = jif.active;
		jls_job_slot u_slot (
			.core_clk(core_clk),
			.rst_n(rst_n),
			.jif(jif)
		);
	end

	// ************************************************************
	// System alarm, heartbeat and host link.
	// ************************************************************
	logic alarm_en_q;
	logic [N_APP-1:0] horn_en_q;
	logic alarm_q;
	logic hb_q;
	logic [HBW-1:0] hb_cnt_q;
	logic link_q;
	wire app_horn = |(app_fault & horn_en_q);
	wire alarm_d = alarm_en_q & (sys_fault | app_horn);
	wire hb_wrap = hb_cnt_q == HBW'(HB_HALF_CYC - 1);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			alarm_q <= 1'b0;
			hb_q <= 1'b0;
			hb_cnt_q <= '0;
			link_q <= 1'b0;
		end else begin
			alarm_q <= alarm_d;
			link_q <= link_s;
			if (fw_err) begin
				hb_q <= 1'b0;
				hb_cnt_q <= '0;
			end else if (hb_wrap) begin
				hb_q <= ~hb_q;
				hb_cnt_q <= '0;
			end else begin
				hb_cnt_q <= hb_cnt_q + 1'b1;
			end
		end
	end

	assign alarm_out = alarm_q;
	assign heartbeat_out = hb_q;
	assign host_link_out = link_q;

	// ************************************************************
	// Register bus and interrupts.
	// ************************************************************
	jls_bus_e bus_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [`JLS_IRQ_W-1:0] irq_stat_q;
	logic [`JLS_IRQ_W-1:0] irq_mask_q;
	logic [`JLS_IRQ_W-1:0] irq_set;
	wire req = avs_read | avs_write;
	wire ans = bus_q == JLS_BUS_ANS;
	wire wr_fire = avs_write & ans;
	wire [31:0] bem = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire [31:0] wd = avs_writedata & bem;
	wire sel_sys = avs_address == `JLS_REG_SYS_CFG;
	wire sel_horn = avs_address == `JLS_REG_HORN_EN;
	wire sel_stat = avs_address == `JLS_REG_IRQ_STAT;
	wire sel_mask = avs_address == `JLS_REG_IRQ_MASK;
	wire [`JLS_IRQ_W-1:0] irq_clr = (wr_fire & sel_stat) ? wd[`JLS_IRQ_W-1:0] : '0;

	assign irq_set[`JLS_IRQ_REJECT] = |rej_evt;
	assign irq_set[`JLS_IRQ_ACTIVATE] = |act_evt;
	assign irq_set[`JLS_IRQ_LINK_LOST] = link_q & ~link_s;
	assign irq_set[`JLS_IRQ_ALARM] = alarm_d & ~alarm_q;
	assign avs_waitrequest = req & ~ans;
	assign avs_readdata = rdata_q;
	assign irq = |(irq_stat_q & irq_mask_q);

	always_comb begin
		rdata_d = '0;
		if (avs_address == `JLS_REG_SYS_CFG) begin
			rdata_d[`JLS_SYS_CFG_ALARM_EN] = alarm_en_q;
		end else if (avs_address == `JLS_REG_HORN_EN) begin
			rdata_d[N_APP-1:0] = horn_en_q;
		end else if (avs_address == `JLS_REG_STATUS) begin
			rdata_d[`JLS_STATUS_ALARM] = alarm_q;
			rdata_d[`JLS_STATUS_HB] = hb_q;
			rdata_d[`JLS_STATUS_LINK] = link_q;
			rdata_d[`JLS_STATUS_FW_ERR] = fw_err;
			rdata_d[`JLS_STATUS_PEND_LSB +: N_APP] = pend_v;
		end else if (avs_address == `JLS_REG_IRQ_STAT) begin
			rdata_d[`JLS_IRQ_W-1:0] = irq_stat_q;
		end else if (avs_address == `JLS_REG_IRQ_MASK) begin
			rdata_d[`JLS_IRQ_W-1:0] = irq_mask_q;
		end
		for (int i = 0; i < N_APP; i++) begin
			if (avs_address == `JLS_REG_JOB_BASE + 8'(4 * i)) begin
				rdata_d[`JLS_JOB_ACTIVE_LSB +: 9] = act_arr[i];
				rdata_d[`JLS_JOB_PEND_LSB +: 9] = pend_arr[i];
				rdata_d[`JLS_JOB_PEND_V] = pend_v[i];
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_q <= JLS_BUS_IDLE;
			rdata_q <= '0;
		end else begin
			bus_q <= (req & ~ans) ? JLS_BUS_ANS : JLS_BUS_IDLE;
			if (avs_read & ~ans) begin
				rdata_q <= rdata_d;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			alarm_en_q <= `JLS_ALARM_EN_RST;
			horn_en_q <= '0;
			irq_mask_q <= `JLS_IRQ_MASK_RST;
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
			if (wr_fire & sel_sys & avs_byteenable[0]) begin
				alarm_en_q <= avs_writedata[`JLS_SYS_CFG_ALARM_EN];
			end
			if (wr_fire & sel_horn) begin
				horn_en_q <= (horn_en_q & ~bem[N_APP-1:0]) | wd[N_APP-1:0];
			end
			if (wr_fire & sel_mask) begin
				irq_mask_q <= (irq_mask_q & ~bem[`JLS_IRQ_W-1:0]) | wd[`JLS_IRQ_W-1:0];
			end
		end
	end

	// ************************************************************
	// Checks.
	// ************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	alarm_sys_a: assert property (sys_fault && alarm_en_q |=> alarm_out)
		else $error("System fault did not raise the alarm.");
	alarm_app_a: assert property ((app_fault & horn_en_q) != '0 && alarm_en_q |=> alarm_out)
		else $error("Enabled applicator fault did not raise alarm.");
	alarm_off_a: assert property (!alarm_en_q |=> !alarm_out)
		else $error("Alarm raised while disabled.");
	hb_stop_a: assert property (fw_err |=> !heartbeat_out && hb_cnt_q == '0)
		else $error("Heartbeat kept running on firmware error.");
	hb_toggle_a: assert property (!fw_err && hb_wrap |=> heartbeat_out != $past(heartbeat_out))
		else $error("Heartbeat missed its toggle.");
	link_follow_a: assert property (host_link_out == $past(link_s))
		else $error("Host link output does not follow the link.");
	cap_single_a: assert property (cap != '0 |=> (cap & $past(cap)) == '0)
		else $error("One strobe gave two captures.");
	bus_answer_a: assert property (req && !ans |=> ans ##1 !ans)
		else $error("Bus answer not given in one wait cycle.");

	// ************************************************************
	// Pin and heartbeat checks.
	// ************************************************************
	strobe_sync_a: assert property ($past(rst_n, 2)
		|-> strobe_s == $past(load_strobe_pin, 2))
		else $error("Load strobe skipped its synchroniser.");
	job_sync_a: assert property ($past(rst_n, 2)
		|-> job_s == $past(job_bcd_pin, 2))
		else $error("Job lines skipped their synchroniser.");
	link_sync_a: assert property ($past(rst_n, 2)
		|-> link_s == $past(link_up_pin, 2))
		else $error("Link pin skipped its synchroniser.");
	hb_bound_a: assert property (hb_cnt_q < HBW'(HB_HALF_CYC))
		else $error("Heartbeat counter ran past its half period.");

	// ************************************************************
	// Register bus and interrupt checks.
	// ************************************************************
	rd_stat_a: assert property (avs_read && !ans && sel_stat
		|=> avs_readdata == 32'($past(irq_stat_q)))
		else $error("Status read returned the wrong bits.");
	rdata_hold_a: assert property (!(avs_read && !ans) |=> $stable(avs_readdata))
		else $error("Read data moved outside a read.");
	sys_cfg_wr_a: assert property (wr_fire && sel_sys && avs_byteenable[0]
		|=> alarm_en_q == $past(avs_writedata[`JLS_SYS_CFG_ALARM_EN]))
		else $error("Alarm enable write did not land.");
	mask_wr_a: assert property (wr_fire && sel_mask && avs_byteenable[0]
		|=> irq_mask_q == $past(avs_writedata[`JLS_IRQ_W-1:0]))
		else $error("Interrupt mask write did not land.");
	irq_set_a: assert property (irq_set != '0
		|=> (irq_stat_q & $past(irq_set)) == $past(irq_set))
		else $error("Interrupt event lost against a clear.");
	irq_clr_a: assert property ((irq_clr & ~irq_set) != '0
		|=> (irq_stat_q & $past(irq_clr) & ~$past(irq_set)) == '0)
		else $error("Interrupt bit survived its clear.");
	link_lost_a: assert property (link_q && !link_s |=> irq_stat_q[`JLS_IRQ_LINK_LOST])
		else $error("Link loss did not flag an interrupt.");
	act_irq_a: assert property (act_evt != '0 |=> irq_stat_q[`JLS_IRQ_ACTIVATE])
		else $error("Job activation did not flag an interrupt.");
	alarm_irq_a: assert property (alarm_d && !alarm_q |=> irq_stat_q[`JLS_IRQ_ALARM])
		else $error("Alarm rise did not flag an interrupt.");
endmodule // jls_top

// >>> dv/jls_plc_model.sv
`timescale 1ns/1ns
module jls_plc_model
	import jls_pkg::*;
#(
	parameter int N_APP = 4
) (
	// Clock.
	input wire logic core_clk,
	// Job load pins.
	output jls_job_t job_bcd_pin,
	output logic [N_APP-1:0] load_strobe_pin
);
	initial begin
		job_bcd_pin = 9'h001;
		load_strobe_pin = '0;
	end
	// Holds the job lines, then pulses one strobe when asked to.
	task automatic load(input int app, input jls_job_t job, input logic stb);
		job_bcd_pin <= job;
		repeat (4) @(posedge core_clk);
		load_strobe_pin[app] <= stb;
		repeat (4) @(posedge core_clk);
		load_strobe_pin[app] <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask
endmodule // jls_plc_model

// >>> dv/tb.sv
`timescale 1ns/1ns
`include "jls_cfg.svh"
module tb;
	import jls_pkg::*;
	localparam int NA = 4;
	logic core_clk, nrst, avs_read, avs_write, link_up_pin, sys_fault, fw_err;
	logic avs_waitrequest, irq, alarm_out, heartbeat_out, host_link_out;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [NA-1:0] app_run, app_fault, load_strobe_pin;
	logic [NA*9-1:0] active_job;
	jls_job_t job_bcd_pin;
	int miscompares, n_tests;
	jls_top #(.N_APP(NA), .HB_HALF_CYC(8)) dut (.core_clk(core_clk), .nrst(nrst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq), .job_bcd_pin(job_bcd_pin),
		.load_strobe_pin(load_strobe_pin), .link_up_pin(link_up_pin), .app_run(app_run),
		.app_fault(app_fault), .sys_fault(sys_fault), .fw_err(fw_err), .alarm_out(alarm_out),
		.heartbeat_out(heartbeat_out), .host_link_out(host_link_out), .active_job(active_job));
	jls_plc_model #(.N_APP(NA)) plc (.core_clk(core_clk), .job_bcd_pin(job_bcd_pin),
		.load_strobe_pin(load_strobe_pin));
	// ********************************
	// Shared tasks.
	// ********************************
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge core_clk);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge core_clk);
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic cnt_hb(output int t);
		logic h;
		t = 0;
		h = heartbeat_out;
		repeat (40) begin
			@(posedge core_clk);
			if (heartbeat_out !== h) t++;
			h = heartbeat_out;
		end
	endtask
	// ********************************
	// Scenarios.
	// ********************************
	task automatic t_regs;
		bus(1'b0, `JLS_REG_SYS_CFG, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, `JLS_REG_HORN_EN, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, 8'hFC, 32'hFFFF_FFFF);
		bus(1'b0, 8'hFC, 32'h0);
		chk(rd, 32'h0);
	endtask
	task automatic t_idle;
		plc.load(0, 9'h123, 1'b1);
		chk(32'(active_job[8:0]), 32'h123);
		plc.load(0, 9'h055, 1'b0);
		chk(32'(active_job[8:0]), 32'h123);
	endtask
	task automatic t_run;
		app_run[1] <= 1'b1;
		plc.load(1, 9'h045, 1'b1);
		chk(32'(active_job[17:9]), 32'h0);
		plc.load(1, 9'h067, 1'b1);
		bus(1'b0, `JLS_REG_JOB_BASE + 8'h04, 32'h0);
		chk(rd, 32'h8067_0000);
		bus(1'b0, `JLS_REG_STATUS, 32'h0);
		chk(rd & 32'h0000_0F00, 32'h0000_0200);
		app_run[1] <= 1'b0;
		wait_cyc(4);
		chk(32'(active_job[17:9]), 32'h067);
		app_run[2] <= 1'b1;
		plc.load(2, 9'h199, 1'b1);
		app_fault[2] <= 1'b1;
		wait_cyc(4);
		chk(32'(active_job[26:18]), 32'h199);
		app_fault[2] <= 1'b0;
		app_run[2] <= 1'b0;
	endtask
	task automatic t_reject;
		jls_job_t bad[3];
		bad = '{9'h1A0, 9'h000, 9'h00A};
		bus(1'b1, `JLS_REG_IRQ_MASK, 32'h1);
		foreach (bad[i]) begin
			plc.load(0, bad[i], 1'b1);
			chk(32'(active_job[8:0]), 32'h123);
			chk(32'(irq), 32'h1);
			bus(1'b1, `JLS_REG_IRQ_STAT, 32'h1);
			chk(32'(irq), 32'h0);
		end
		bus(1'b1, `JLS_REG_IRQ_MASK, 32'h0);
	endtask
	task automatic t_alarm;
		sys_fault <= 1'b1;
		wait_cyc(3);
		chk(32'(alarm_out), 32'h0);
		bus(1'b1, `JLS_REG_SYS_CFG, 32'h1);
		wait_cyc(3);
		chk(32'(alarm_out), 32'h1);
		sys_fault <= 1'b0;
		app_fault[0] <= 1'b1;
		bus(1'b1, `JLS_REG_HORN_EN, 32'h0);
		wait_cyc(3);
		chk(32'(alarm_out), 32'h0);
		bus(1'b1, `JLS_REG_HORN_EN, 32'h1);
		wait_cyc(3);
		chk(32'(alarm_out), 32'h1);
		bus(1'b1, `JLS_REG_SYS_CFG, 32'h0);
		wait_cyc(3);
		chk(32'(alarm_out), 32'h0);
		app_fault[0] <= 1'b0;
	endtask
	task automatic t_hb_link;
		int t;
		cnt_hb(t);
		chk(32'(t), 32'd5);
		fw_err <= 1'b1;
		wait_cyc(4);
		cnt_hb(t);
		chk(32'(t), 32'd0);
		fw_err <= 1'b0;
		link_up_pin <= 1'b1;
		wait_cyc(5);
		chk(32'(host_link_out), 32'h1);
		link_up_pin <= 1'b0;
		wait_cyc(5);
		chk(32'(host_link_out), 32'h0);
		bus(1'b0, `JLS_REG_IRQ_STAT, 32'h0);
		chk(rd & 32'h4, 32'h4);
	endtask
	task automatic test_done;
		$display("comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		nrst = 1'b0;
		{avs_read, avs_write, link_up_pin, sys_fault, fw_err} = '0;
		avs_address = 8'h00;
		avs_writedata = 32'h0;
		app_run = '0;
		app_fault = '0;
		miscompares = 0;
		n_tests = 0;
		wait_cyc(20);
		nrst <= 1'b1;
		wait_cyc(4);
		t_regs();
		t_idle();
		t_run();
		t_reject();
		t_alarm();
		t_hb_link();
		test_done();
	end
	initial begin
		wait_cyc(4000);
		miscompares++;
		test_done();
	end
endmodule // tb
